/* instrument_bus_interface.sv */
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Receivers mirror lines; drive only when enabled
// - Bus lines active low, local side high
// - Never assert ATN, IFC or REN
// - Service request bit drives SRQ
// - Handshake drivers on when addressed or ATN
// - Data drivers only in talk without ATN
// - Received data passed only in listen
// - Source handshake output only in talk
// - Acceptor enable and event use direction
// - Filter both edges of four inputs
// - Capture ATN, IFC, handshake event edges
// - Flag set when NRFD and NDAC idle
// - Data port moves bytes; events raise flags
// - Strobe forwarded to source and acceptor
// - Event on listen with DAV, talk ready
// - ATN at once enables acceptor, blocks data
module instrument_bus_interface
#(
  parameter int DEB_CYCLES = instrument_bus_pkg::DEB_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Data lines, active low, open collector
  input wire logic [7:0] dio_n_line,
  output logic [7:0] dio_n_drive,
  output logic [7:0] dio_drive_en,
  // Transfer lines, active low, open collector
  input wire logic dav_n_line,
  output logic dav_n_drive,
  output logic dav_drive_en,
  input wire logic nrfd_n_line,
  output logic nrfd_n_drive,
  output logic nrfd_drive_en,
  input wire logic ndac_n_line,
  output logic ndac_n_drive,
  output logic ndac_drive_en,
  input wire logic eoi_n_line,
  output logic eoi_n_drive,
  output logic eoi_drive_en,
  // Management lines, active low, open collector
  input wire logic atn_n_line,
  output logic atn_n_drive,
  output logic atn_drive_en,
  input wire logic ifc_n_line,
  output logic ifc_n_drive,
  output logic ifc_drive_en,
  output logic ren_n_drive,
  output logic ren_drive_en,
  output logic srq_n_drive,
  output logic srq_drive_en
);
  import instrument_bus_pkg::*;

  // ==========================================================
  // Control state
  logic direction_select_bit;
  logic addressed_bit;
  logic srq_req;
  logic eoi_req;
  logic [7:0] tx_byte;
  logic handshake_strobe;

  // Bus line levels seen from the local side, active high
  logic atn_act;
  logic dav_act;
  logic nrfd_act;
  logic ndac_act;
  logic eoi_act;
  logic ifc_act;
  logic [7:0] rx_byte;

  // Steering
  logic listen;
  logic talk;
  logic hs_enable;
  logic ah_enable;
  logic hand_raw;

  // Filtered levels and their previous values
  logic atn_clean;
  logic ifc_clean;
  logic ndac_clean;
  logic hand_clean;
  logic atn_prev;
  logic ifc_prev;
  logic hand_prev;
  logic [EV_WIDTH-1:0] events;
  logic [EV_WIDTH-1:0] ev_set;
  logic [EV_WIDTH-1:0] ev_clr;

  // Handshake state
  logic sh_dav;
  logic ah_hold;
  logic nobody;

  // Bus slave
  logic take;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] next_rdata;

  // ==========================================================
  // Receive side inversion
  assign atn_act = ~atn_n_line;
  assign ifc_act = ~ifc_n_line;
  assign dav_act = ~dav_n_line;
  assign nrfd_act = ~nrfd_n_line;
  assign ndac_act = ~ndac_n_line;
  assign eoi_act = ~eoi_n_line;
  assign rx_byte = ~dio_n_line;

  // ==========================================================
  // Listen/talk steering; raw ATN acts without waiting for the filter
  assign listen = direction_select_bit | atn_act;
  assign talk = ~listen;
  assign hs_enable = addressed_bit | atn_act;
  assign ah_enable = direction_select_bit | atn_act;
  assign hand_raw = (direction_select_bit & dav_act) | (~direction_select_bit & ~nrfd_act);

  // ==========================================================
  // Filters for ATN, IFC, NDAC and the handshake event
  line_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_atn
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .raw(atn_act),
    .clean(atn_clean)
  );

  line_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_ifc
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .raw(ifc_act),
    .clean(ifc_clean)
  );

  line_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_ndac
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .raw(ndac_act),
    .clean(ndac_clean)
  );

  line_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_hand
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .raw(hand_raw),
    .clean(hand_clean)
  );

  // ==========================================================
  // Edge capture; a pulse shorter than a poll interval still leaves a flag
  assign ev_set[EV_ATN_BIT] = atn_clean ^ atn_prev;
  assign ev_set[EV_IFC_BIT] = ifc_clean & ~ifc_prev;
  assign ev_set[EV_HAND_BIT] = hand_clean & ~hand_prev;
  assign ev_clr = (wr_pend && wr_addr == OFS_EVENTS) ? hwdata[EV_WIDTH-1:0] : '0;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      atn_prev <= 1'b0;
      ifc_prev <= 1'b0;
      hand_prev <= 1'b0;
    end
    else
    begin
      atn_prev <= atn_clean;
      ifc_prev <= ifc_clean;
      hand_prev <= hand_clean;
    end
  end

  // Set beats clear so an edge in the clearing cycle survives
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      events <= '0;
    end
    else
    begin
      events <= ev_set | (events & ~ev_clr);
    end
  end

  // ==========================================================
  // No-listener detector
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nobody <= 1'b0;
    end
    else
    begin
      nobody <= ~nrfd_act & ~ndac_act;
    end
  end

  // ==========================================================
  // Source handshake: strobe raises DAV, accepted data drops it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_dav <= 1'b0;
    end
    else if (listen)
    begin
      sh_dav <= 1'b0;
    end
    else if (handshake_strobe)
    begin
      sh_dav <= 1'b1;
    end
    else if (!ndac_clean)
    begin
      sh_dav <= 1'b0;
    end
  end

  // Acceptor hold: NDAC stays until the processor strobes after reading
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ah_hold <= 1'b1;
    end
    else if (!dav_act)
    begin
      ah_hold <= 1'b1;
    end
    else if (handshake_strobe && listen)
    begin
      ah_hold <= 1'b0;
    end
  end

  // ==========================================================
  // Line drivers; pulling low is the only drive, enables pick who pulls
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dio_drive_en <= '0;
      dav_drive_en <= 1'b0;
      nrfd_drive_en <= 1'b0;
      ndac_drive_en <= 1'b0;
      eoi_drive_en <= 1'b0;
      srq_drive_en <= 1'b0;
    end
    else
    begin
      dio_drive_en <= (talk & ~atn_act) ? tx_byte : '0;
      dav_drive_en <= hs_enable & talk & sh_dav;
      nrfd_drive_en <= hs_enable & ah_enable & (dav_act | hand_clean);
      ndac_drive_en <= hs_enable & ah_enable & ah_hold;
      eoi_drive_en <= hs_enable & talk & eoi_req;
      srq_drive_en <= srq_req;
    end
  end

  // Management lines that this device may never assert
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      atn_drive_en <= 1'b0;
      ifc_drive_en <= 1'b0;
      ren_drive_en <= 1'b0;
    end
    else
    begin
      atn_drive_en <= 1'b0;
      ifc_drive_en <= 1'b0;
      ren_drive_en <= 1'b0;
    end
  end

  // Drive values are always low, a released line floats high
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dio_n_drive <= '0;
      dav_n_drive <= 1'b0;
      nrfd_n_drive <= 1'b0;
      ndac_n_drive <= 1'b0;
      eoi_n_drive <= 1'b0;
      atn_n_drive <= 1'b0;
      ifc_n_drive <= 1'b0;
      ren_n_drive <= 1'b0;
      srq_n_drive <= 1'b0;
    end
    else
    begin
      dio_n_drive <= '0;
      dav_n_drive <= 1'b0;
      nrfd_n_drive <= 1'b0;
      ndac_n_drive <= 1'b0;
      eoi_n_drive <= 1'b0;
      atn_n_drive <= 1'b0;
      ifc_n_drive <= 1'b0;
      ren_n_drive <= 1'b0;
      srq_n_drive <= 1'b0;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  assign take = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == 2'h3);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Address phase of a write is held for its data phase
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else
    begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr[11:0];
    end
  end

  // Read data is chosen in the address phase and stands in the data phase
  always_comb
  begin
    next_rdata = RST_RDATA;
    case (haddr[11:0])
      OFS_CTRL:
      begin
        next_rdata[CTRL_DIR_BIT] = direction_select_bit;
        next_rdata[CTRL_ADDR_BIT] = addressed_bit;
        next_rdata[CTRL_SRQ_BIT] = srq_req;
        next_rdata[CTRL_EOI_BIT] = eoi_req;
      end
      OFS_DATA:
      begin
        next_rdata[7:0] = listen ? rx_byte : 8'h00;
      end
      OFS_STATUS:
      begin
        next_rdata[STAT_ATN_BIT] = atn_clean;
        next_rdata[STAT_IFC_BIT] = ifc_clean;
        next_rdata[STAT_NDAC_BIT] = ndac_clean;
        next_rdata[STAT_HAND_BIT] = hand_clean;
        next_rdata[STAT_NOBODY_BIT] = nobody;
        next_rdata[STAT_EOI_BIT] = eoi_act & listen;
        next_rdata[STAT_LISTEN_BIT] = listen;
      end
      OFS_EVENTS:
      begin
        next_rdata[EV_WIDTH-1:0] = events;
      end
      default:
      begin
        next_rdata = RST_RDATA;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hrdata <= RST_RDATA;
    end
    else if (take && !hwrite)
    begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================
  // Control and data registers written by software
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      direction_select_bit <= RST_DIR_LISTEN;
      addressed_bit <= 1'b0;
      srq_req <= 1'b0;
      eoi_req <= 1'b0;
    end
    else if (wr_pend && wr_addr == OFS_CTRL)
    begin
      direction_select_bit <= hwdata[CTRL_DIR_BIT];
      addressed_bit <= hwdata[CTRL_ADDR_BIT];
      srq_req <= hwdata[CTRL_SRQ_BIT];
      eoi_req <= hwdata[CTRL_EOI_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_byte <= RST_TX_BYTE;
    end
    else if (wr_pend && wr_addr == OFS_DATA)
    begin
      tx_byte <= hwdata[7:0];
    end
  end

  // Strobe is a one-cycle pulse, it never reads back
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      handshake_strobe <= 1'b0;
    end
    else
    begin
      handshake_strobe <= wr_pend & (wr_addr == OFS_CTRL) & hwdata[CTRL_STROBE_BIT];
    end
  end

endmodule

`default_nettype wire

/* instrument_bus_pkg.sv */
package instrument_bus_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DATA = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_EVENTS = 12'h00c;

  // ==========================================================
  // Control register fields
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_ADDR_BIT = 1;
  localparam int CTRL_SRQ_BIT = 2;
  localparam int CTRL_EOI_BIT = 3;
  localparam int CTRL_STROBE_BIT = 4;

  // ==========================================================
  // Status register fields
  localparam int STAT_ATN_BIT = 0;
  localparam int STAT_IFC_BIT = 1;
  localparam int STAT_NDAC_BIT = 2;
  localparam int STAT_HAND_BIT = 3;
  localparam int STAT_NOBODY_BIT = 4;
  localparam int STAT_EOI_BIT = 5;
  localparam int STAT_LISTEN_BIT = 6;

  // ==========================================================
  // Event capture fields
  localparam int EV_ATN_BIT = 0;
  localparam int EV_IFC_BIT = 1;
  localparam int EV_HAND_BIT = 2;
  localparam int EV_WIDTH = 3;

  // ==========================================================
  // Reset values
  localparam logic RST_DIR_LISTEN = 1'b1;
  localparam logic [7:0] RST_TX_BYTE = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEB_TIME_NS = 20000;
  localparam int DEB_CYCLES_DEF = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CNT_W = 12;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

/* line_debounce.sv */
`timescale 1ns/1ps
`default_nettype none

module line_debounce
#(
  parameter int STABLE_CYCLES = instrument_bus_pkg::DEB_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Raw level and its filtered copy
  input wire logic raw,
  output logic clean
);
  import instrument_bus_pkg::*;

  logic sync_a;
  logic sync_b;
  logic [DEB_CNT_W-1:0] count;

  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // Both edges must hold steady the full window, so ringing never passes
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0;
      clean <= 1'b0;
    end
    else if (sync_b == clean)
    begin
      count <= '0;
    end
    else if (count == DEB_CNT_W'(STABLE_CYCLES - 1))
    begin
      count <= '0;
      clean <= sync_b;
    end
    else
    begin
      count <= count + 1'b1;
    end
  end

endmodule

`default_nettype wire

/* ibi_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module ibi_checker
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Bus lines
  input wire logic [7:0] dio_drive_en,
  input wire logic dav_n_line,
  input wire logic dav_drive_en,
  input wire logic nrfd_drive_en,
  input wire logic ndac_drive_en,
  input wire logic atn_n_line,
  input wire logic atn_drive_en,
  input wire logic ifc_drive_en,
  input wire logic ren_drive_en,
  input wire logic srq_drive_en,
  // Drive values, pulling low is the only drive
  input wire logic [7:0] dio_n_drive,
  input wire logic dav_n_drive,
  input wire logic nrfd_n_drive,
  input wire logic ndac_n_drive,
  input wire logic eoi_n_drive,
  input wire logic atn_n_drive,
  input wire logic ifc_n_drive,
  input wire logic ren_n_drive,
  input wire logic srq_n_drive
);
  import instrument_bus_pkg::*;
  logic wr_ctrl;
  logic dir;
  logic adr;
  logic srq;
  logic stb;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Shadow of the control word, so no check needs a register read
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ctrl <= 1'b0;
      dir <= RST_DIR_LISTEN;
      adr <= 1'b0;
      srq <= 1'b0;
      stb <= 1'b0;
    end
    else
    begin
      wr_ctrl <= hsel && htrans[1] && hwrite && (haddr[11:0] == OFS_CTRL);
      stb <= wr_ctrl && hwdata[CTRL_STROBE_BIT];
      if (wr_ctrl)
      begin
        dir <= hwdata[CTRL_DIR_BIT];
        adr <= hwdata[CTRL_ADDR_BIT];
        srq <= hwdata[CTRL_SRQ_BIT];
      end
    end
  end
  // ==========
  // Properties
  sequence s_strobe_talk;
    stb && !dir && adr && atn_n_line;
  endsequence
  a_mgmt_quiet: assert property (!(atn_drive_en || ifc_drive_en || ren_drive_en))
    else $error("management line driven");
  a_bus_okay: assert property ($past(arst_n) |-> hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_srq_follow: assert property ($stable(srq) |-> ##[0:1] (srq_drive_en == srq))
    else $error("service request drive wrong");
  a_dav_listen: assert property (dir && $past(dir) && $past(dir, 2) |-> !dav_drive_en)
    else $error("source handshake in listen");
  a_data_talk_only: assert property (!$past(atn_n_line) || (dir && $past(dir)) |-> dio_drive_en == 8'h00)
    else $error("data driven outside talk");
  a_hs_idle_off: assert property (atn_n_line && $past(atn_n_line) && !adr && !$past(adr)
    |-> !(dav_drive_en || nrfd_drive_en || ndac_drive_en))
    else $error("handshake driven while idle");
  a_nrfd_on_dav: assert property ((!atn_n_line && !dav_n_line)[*2] |-> nrfd_drive_en)
    else $error("no ready hold under attention");
  a_dav_strobe: assert property (s_strobe_talk |-> ##[1:2] dav_drive_en)
    else $error("strobe did not raise data valid");
  a_drive_low: assert property ({dio_n_drive, dav_n_drive, nrfd_n_drive, ndac_n_drive, eoi_n_drive,
    atn_n_drive, ifc_n_drive, ren_n_drive, srq_n_drive} == 16'h0000)
    else $error("line drive value not low");
endmodule
`default_nettype wire

/* bus_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Far-side listener and talker
module bus_peer
(
  // Clock
  input wire logic core_clk,
  // Device drive enables
  input wire logic [7:0] dio_drive_en,
  input wire logic dav_drive_en,
  input wire logic nrfd_drive_en,
  input wire logic ndac_drive_en,
  input wire logic eoi_drive_en,
  // Instrument controls
  input wire logic listener_on,
  input wire logic talk_dav,
  input wire logic [7:0] talk_byte,
  // Wire levels, pulled up when released
  output logic [7:0] dio_n_line,
  output logic dav_n_line,
  output logic nrfd_n_line,
  output logic ndac_n_line,
  output logic eoi_n_line
);
  logic [2:0] acc = 3'h0;
  // Slow listener: seven cycles per byte, so the talker must wait
  always @(posedge core_clk)
  begin
    if (dav_n_line)
      acc <= 3'h0;
    else if (acc != 3'h7)
      acc <= acc + 3'h1;
  end
  // Open-collector wired-AND of both parties
  assign dio_n_line = ~(dio_drive_en | (talk_dav ? talk_byte : 8'h00));
  assign dav_n_line = ~(dav_drive_en | talk_dav);
  assign nrfd_n_line = ~(nrfd_drive_en | (listener_on & ~dav_n_line));
  assign ndac_n_line = ~(ndac_drive_en | (listener_on & (acc != 3'h7)));
  assign eoi_n_line = ~eoi_drive_en;
endmodule
`default_nettype wire

/* instrument_bus_interface_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin errors++; $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
// ==========
// Bench top
module instrument_bus_interface_tb_top;
  import instrument_bus_pkg::*;
  logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp, listener_on, talk_dav;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] dio_n_line, dio_drive_en, talk_byte;
  logic dav_n_line, dav_drive_en, nrfd_n_line, nrfd_drive_en, ndac_n_line, ndac_drive_en, eoi_n_line;
  logic eoi_drive_en, atn_n_line, atn_drive_en, ifc_n_line, ifc_drive_en, ren_drive_en, srq_drive_en;
  int errors = 0;
  int samples_checked = 0;
  // Short filter keeps event waits brief
  instrument_bus_interface #(.DEB_CYCLES(4)) instrument_bus_interface_i (.core_clk, .arst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dio_n_line,
    .dio_n_drive(), .dio_drive_en, .dav_n_line, .dav_n_drive(), .dav_drive_en, .nrfd_n_line, .nrfd_n_drive(),
    .nrfd_drive_en, .ndac_n_line, .ndac_n_drive(), .ndac_drive_en, .eoi_n_line, .eoi_n_drive(), .eoi_drive_en,
    .atn_n_line, .atn_n_drive(), .atn_drive_en, .ifc_n_line, .ifc_n_drive(), .ifc_drive_en, .ren_n_drive(),
    .ren_drive_en, .srq_n_drive(), .srq_drive_en);
  bus_peer bus_peer_i (.core_clk, .dio_drive_en, .dav_drive_en, .nrfd_drive_en, .ndac_drive_en, .eoi_drive_en,
    .listener_on, .talk_dav, .talk_byte, .dio_n_line, .dav_n_line, .nrfd_n_line, .ndac_n_line, .eoi_n_line);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Waits for ready; a slave that never answers ends the run
  task automatic hwait();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
  endtask
  // One single word transfer; read data lands in q
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask
  // Polls a status bit under a bound
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (q[b] !== v && n < 40);
    `CHK("status bit", v, q[b])
    if (q[b] !== v)
      give_verdict();
  endtask
  // Quiet after reset; service request follows its bit
  task automatic t_reset();
    ahb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 5'h01, q[4:0])
    ahb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 32'h0, q)
    ahb(1'b1, OFS_EVENTS, 32'h7);
    `CHK("mgmt drive", 3'h0, {atn_drive_en, ifc_drive_en, ren_drive_en})
    ahb(1'b1, OFS_CTRL, 32'h5);
    repeat (2) @(posedge core_clk);
    `CHK("srq on", 1'b1, srq_drive_en)
    ahb(1'b1, OFS_CTRL, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK("srq off", 1'b0, srq_drive_en)
  endtask
  // Listener leaves and returns
  task automatic t_nobody();
    listener_on <= 1'b0;
    wait_stat(STAT_NOBODY_BIT, 1'b1);
    // Nobody there: the port is still in listen, so neither DAV nor data goes out
    `CHK("idle while alone", 9'h000, {dav_drive_en, dio_drive_en})
    listener_on <= 1'b1;
    wait_stat(STAT_NOBODY_BIT, 1'b0);
  endtask
  // Talk one byte to a slow listener, then attention takes the bus back
  task automatic t_talk();
    int n;
    ahb(1'b1, OFS_DATA, 32'ha5);
    ahb(1'b1, OFS_CTRL, 32'h2);
    wait_stat(STAT_HAND_BIT, 1'b1);
    `CHK("listener seen", 1'b0, q[STAT_NOBODY_BIT])
    `CHK("data drive", 8'ha5, dio_drive_en)
    `CHK("data wire", 8'h5a, dio_n_line)
    ahb(1'b0, OFS_DATA, 32'h0);
    `CHK("talk read", 32'h0, q)
    ahb(1'b0, OFS_EVENTS, 32'h0);
    `CHK("hand event", 1'b1, q[EV_HAND_BIT])
    // Strobe with end flag; the source flop is set first, its drive follows one edge later
    ahb(1'b1, OFS_CTRL, 32'h1a);
    repeat (3) @(posedge core_clk);
    `CHK("dav drive", 1'b1, dav_drive_en)
    `CHK("eoi drive", 1'b1, eoi_drive_en)
    for (n = 0; n < 60 && dav_drive_en !== 1'b0; n++)
      @(posedge core_clk);
    `CHK("dav release", 1'b0, dav_drive_en)
    if (dav_drive_en !== 1'b0)
      give_verdict();
    atn_n_line <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("data under atn", 8'h00, dio_drive_en)
    wait_stat(STAT_ATN_BIT, 1'b1);
    ahb(1'b0, OFS_EVENTS, 32'h0);
    `CHK("atn event", 1'b1, q[EV_ATN_BIT])
    atn_n_line <= 1'b1;
  endtask
  // Controller sends a byte under attention; the port accepts it
  task automatic t_listen();
    ahb(1'b1, OFS_CTRL, 32'h1);
    atn_n_line <= 1'b0;
    talk_byte <= 8'h3c;
    talk_dav <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK("nrfd hold", 1'b1, nrfd_drive_en)
    ahb(1'b0, OFS_DATA, 32'h0);
    `CHK("listen read", 32'h3c, q)
    wait_stat(STAT_HAND_BIT, 1'b1);
    `CHK("ndac hold", 1'b1, ndac_drive_en)
    ahb(1'b1, OFS_CTRL, 32'h11);
    repeat (3) @(posedge core_clk);
    `CHK("ndac release", 1'b0, ndac_drive_en)
    talk_dav <= 1'b0;
    atn_n_line <= 1'b1;
  endtask
  // Interface clear pulse is trapped until cleared
  task automatic t_ifc();
    ifc_n_line <= 1'b0;
    repeat (12) @(posedge core_clk);
    ifc_n_line <= 1'b1;
    wait_stat(STAT_IFC_BIT, 1'b0);
    ahb(1'b0, OFS_EVENTS, 32'h0);
    `CHK("ifc event", 1'b1, q[EV_IFC_BIT])
    ahb(1'b1, OFS_EVENTS, 32'h7);
    ahb(1'b0, OFS_EVENTS, 32'h0);
    `CHK("events cleared", 3'h0, q[2:0])
  endtask
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    listener_on = 1'b1;
    talk_dav = 1'b0;
    talk_byte = 8'h00;
    atn_n_line = 1'b1;
    ifc_n_line = 1'b1;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_nobody();
    t_talk();
    t_listen();
    t_ifc();
    give_verdict();
  end
endmodule
bind instrument_bus_interface ibi_checker ibi_checker_i (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hreadyout, .hresp, .dio_drive_en, .dav_n_line, .dav_drive_en, .nrfd_drive_en, .ndac_drive_en,
  .atn_n_line, .atn_drive_en, .ifc_drive_en, .ren_drive_en, .srq_drive_en, .dio_n_drive, .dav_n_drive,
  .nrfd_n_drive, .ndac_n_drive, .eoi_n_drive, .atn_n_drive, .ifc_n_drive, .ren_n_drive, .srq_n_drive);
`default_nettype wire
